// ==== qdi_map.vh ====
// Purpose: register offsets, fields and reset values of the decoder irq block
// Assumes: 32-bit aligned word registers on an AXI4-Lite slave
// Notes: definitions only
`ifndef QDI_MAP_VH
`define QDI_MAP_VH
`define QDI_ADDR_W 12
`define QDI_OFF_STATUS 12'h100
`define QDI_OFF_EN_SET 12'h304
`define QDI_OFF_EN_CLR 12'h308
`define QDI_OFF_RPT_PER 12'h510
`define QDI_OFF_MOTION 12'h514
`define QDI_OFF_DBL 12'h518
`define QDI_IX_STATUS 10'h040
`define QDI_IX_EN_SET 10'h0C1
`define QDI_IX_EN_CLR 10'h0C2
`define QDI_IX_RPT_PER 10'h144
`define QDI_IX_MOTION 10'h145
`define QDI_IX_DBL 10'h146
`define QDI_NEV 5
`define QDI_BIT_SAMPLE 0
`define QDI_BIT_REPORT 1
`define QDI_BIT_OVFL 2
`define QDI_BIT_DBL 3
`define QDI_BIT_STOPPED 4
`define QDI_EN_RST 5'h00
`define QDI_STS_RST 5'h00
`define QDI_RP_RST 4'h0
`define QDI_RP_CNT0 10'h00A
`define QDI_RP_CNT1 10'h028
`define QDI_RP_CNT2 10'h050
`define QDI_RP_CNT3 10'h078
`define QDI_RP_CNT4 10'h0A0
`define QDI_RP_CNT5 10'h168
`define QDI_RP_CNT6 10'h2D0
`define QDI_RP_CNT7 10'h3FF
`define QDI_RP_CNT_DEF 10'h001
`define QDI_RESP_OKAY 2'h0
`define QDI_RESP_SLVERR 2'h2
`endif

// ==== qdi_report.v ====
// Purpose: counts samples and raises the two report events
// Assumes: sample pulses and accumulator values from same clock
// Notes: period table maps setting to sample count
`timescale 1ns/1ps
`default_nettype none
`include "qdi_map.vh"
module qdi_report (
    input wire clk,
    input wire rst_b,
    input wire sample_pulse,
    input wire [3:0] period_sel,
    input wire motion_nonzero,
    input wire dbl_nonzero,
    output reg report_pulse_q,
    output reg dbl_pulse_q
);
    reg [9:0] cnt_q;
    reg [9:0] limit;
    always @* begin
        case (period_sel)
            4'h0: limit = `QDI_RP_CNT0;
            4'h1: limit = `QDI_RP_CNT1;
            4'h2: limit = `QDI_RP_CNT2;
            4'h3: limit = `QDI_RP_CNT3;
            4'h4: limit = `QDI_RP_CNT4;
            4'h5: limit = `QDI_RP_CNT5;
            4'h6: limit = `QDI_RP_CNT6;
            4'h7: limit = `QDI_RP_CNT7;
            default: limit = `QDI_RP_CNT_DEF;
        endcase
    end
    // pulse only at the period end: report if motion was seen, double report if the double sum is nonzero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 10'h000;
            report_pulse_q <= 1'b0;
            dbl_pulse_q <= 1'b0;
        end else begin
            report_pulse_q <= 1'b0;
            dbl_pulse_q <= 1'b0;
            if (sample_pulse) begin
                if (cnt_q + 10'h001 >= limit) begin
                    cnt_q <= 10'h000;
                    report_pulse_q <= motion_nonzero;
                    dbl_pulse_q <= dbl_nonzero;
                end else begin
                    cnt_q <= cnt_q + 10'h001;
                end
            end
        end
    end
endmodule // qdi_report
`default_nettype wire

// ==== qdi_top.v ====
// Purpose: interrupt enable and event logic of a quadrature decoder
// Assumes: AXI4-Lite register access, single clock SYS_CLK
// Notes: event inputs are same-clock one-cycle pulses
// Summary of operation
// - bit 0 of set enables and of clear disables the sample ready irq.
// - writing ones to the clear register disables those events' irqs.
// - bit 1 enables or disables the report ready irq.
// - bit 2 enables or disables the accumulator overflow irq.
// - bit 3 enables or disables the double report ready irq.
// - bit 4 enables or disables the stopped irq.
// - both set and clear registers read back the current enable mask.
// - report ready fires at period end only if the motion sum is nonzero.
// - double report fires at period end only if the double sum is nonzero.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "qdi_map.vh"
module qdi_top (
    input wire SYS_CLK,
    input wire RST_B,
    input wire [11:0] AWADDR,
    input wire AWVALID,
    output wire AWREADY,
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output wire WREADY,
    output reg [1:0] BRESP,
    output reg BVALID,
    input wire BREADY,
    input wire [11:0] ARADDR,
    input wire ARVALID,
    output wire ARREADY,
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    output reg RVALID,
    input wire RREADY,
    input wire SAMPLE_EVT,
    input wire OVFL_EVT,
    input wire STOPPED_EVT,
    input wire [15:0] MOTION_SUM,
    input wire [15:0] DBL_SUM,
    output wire IRQ
);
    // mask, sticky status and report period
    reg [4:0] en_q;
    reg [4:0] sts_q;
    reg [3:0] rp_q;
    reg [3:0] rp_d;
    wire [4:0] en_d;
    wire [4:0] sts_d;

    // write channel holding registers
    reg [11:0] awaddr_q;
    reg aw_held_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_held_q;

    // read decode
    reg [31:0] rd_d;
    reg rd_ok;

    // events and handshake terms
    wire report_pulse;
    wire dbl_pulse;
    wire motion_nz;
    wire dbl_nz;
    wire [4:0] ev;
    wire aw_take;
    wire w_take;
    wire b_take;
    wire ar_take;
    wire r_take;
    wire do_wr;
    wire [11:0] wa;
    wire [9:0] wa_ix;
    wire [9:0] ra_ix;
    wire [31:0] wd;
    wire [3:0] ws;
    wire [4:0] wbits;
    wire wr_set;
    wire wr_clr;
    wire wr_sts;
    wire wr_rp;
    wire wr_ro;
    wire wr_ok;
    wire [4:0] set_bits;
    wire [4:0] clr_bits;
    wire [4:0] ack_bits;
    wire [4:0] pend;
    genvar gi;

    // one clean bit each, so the counter needs no wide compare
    assign motion_nz = (MOTION_SUM != 16'h0000);
    assign dbl_nz = (DBL_SUM != 16'h0000);

    qdi_report u_report (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .sample_pulse(SAMPLE_EVT),
        .period_sel(rp_q),
        .motion_nonzero(motion_nz),
        .dbl_nonzero(dbl_nz),
        .report_pulse_q(report_pulse),
        .dbl_pulse_q(dbl_pulse)
    );

    assign ev[`QDI_BIT_SAMPLE] = SAMPLE_EVT;
    assign ev[`QDI_BIT_REPORT] = report_pulse;
    assign ev[`QDI_BIT_OVFL] = OVFL_EVT;
    assign ev[`QDI_BIT_DBL] = dbl_pulse;
    assign ev[`QDI_BIT_STOPPED] = STOPPED_EVT;

    // address and data may arrive in either order; latch each
    assign AWREADY = !aw_held_q && !BVALID;
    assign WREADY = !w_held_q && !BVALID;
    assign aw_take = AWVALID && AWREADY;
    assign w_take = WVALID && WREADY;
    assign b_take = BVALID && BREADY;
    assign do_wr = (aw_held_q || aw_take) &&
                   (w_held_q || w_take);

    assign wa = aw_held_q ? awaddr_q : AWADDR;
    assign wd = w_held_q ? wdata_q : WDATA;
    assign ws = w_held_q ? wstrb_q : WSTRB;
    assign wa_ix = wa[11:2];

    // only byte lane 0 carries the event bits
    assign wbits = ws[0] ? wd[4:0] : 5'h00;

    assign wr_set = do_wr && (wa_ix == `QDI_IX_EN_SET);
    assign wr_clr = do_wr && (wa_ix == `QDI_IX_EN_CLR);
    assign wr_sts = do_wr && (wa_ix == `QDI_IX_STATUS);
    assign wr_rp = do_wr && (wa_ix == `QDI_IX_RPT_PER);
    // accumulator copies are read only: write accepted, dropped
    assign wr_ro = (wa_ix == `QDI_IX_MOTION) ||
                   (wa_ix == `QDI_IX_DBL);
    assign wr_ok = wr_set || wr_clr || wr_sts || wr_rp ||
                   wr_ro;

    assign set_bits = wr_set ? wbits : 5'h00;
    assign clr_bits = wr_clr ? wbits : 5'h00;
    assign ack_bits = wr_sts ? wbits : 5'h00;

    generate
        for (gi = 0; gi < `QDI_NEV; gi = gi + 1) begin : g_bit
            // zero bits leave the mask alone
            assign en_d[gi] = clr_bits[gi] ? 1'b0 :
                              set_bits[gi] ? 1'b1 :
                              en_q[gi];
            // event set wins over a same-cycle write-one clear
            assign sts_d[gi] = ev[gi] ? 1'b1 :
                               ack_bits[gi] ? 1'b0 :
                               sts_q[gi];
        end
    endgenerate

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            en_q <= `QDI_EN_RST;
        end else begin
            en_q <= en_d;
        end
    end

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sts_q <= `QDI_STS_RST;
        end else begin
            sts_q <= sts_d;
        end
    end

    always @* begin
        rp_d = rp_q;
        if (wr_rp && ws[0]) begin
            rp_d = wd[3:0];
        end
    end

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rp_q <= `QDI_RP_RST;
        end else begin
            rp_q <= rp_d;
        end
    end

    assign pend = sts_q & en_q;
    assign IRQ = |pend;

    // address side parks until the data side arrives
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held_q <= 1'b0;
        end else if (do_wr) begin
            aw_held_q <= 1'b0;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
        end
    end

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            awaddr_q <= 12'h000;
        end else if (aw_take && !do_wr) begin
            awaddr_q <= AWADDR;
        end
    end

    // data side parks the same way, strobes with it
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            w_held_q <= 1'b0;
        end else if (do_wr) begin
            w_held_q <= 1'b0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
        end
    end

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (w_take && !do_wr) begin
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
        end
    end

    // response the cycle after both sides are in
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BVALID <= 1'b0;
        end else if (do_wr) begin
            BVALID <= 1'b1;
        end else if (b_take) begin
            BVALID <= 1'b0;
        end
    end

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BRESP <= `QDI_RESP_OKAY;
        end else if (do_wr) begin
            BRESP <= wr_ok ? `QDI_RESP_OKAY : `QDI_RESP_SLVERR;
        end
    end

    // read path: one-cycle answer, held until RREADY
    assign ARREADY = !RVALID;
    assign ar_take = ARVALID && ARREADY;
    assign r_take = RVALID && RREADY;
    assign ra_ix = ARADDR[11:2];

    always @* begin
        rd_d = 32'h00000000;
        rd_ok = 1'b1;
        case (ra_ix)
            `QDI_IX_EN_SET: rd_d = {27'h0, en_q};
            `QDI_IX_EN_CLR: rd_d = {27'h0, en_q};
            `QDI_IX_STATUS: rd_d = {27'h0, sts_q};
            `QDI_IX_RPT_PER: rd_d = {28'h0, rp_q};
            `QDI_IX_MOTION: rd_d = {16'h0, MOTION_SUM};
            `QDI_IX_DBL: rd_d = {16'h0, DBL_SUM};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RVALID <= 1'b0;
        end else if (ar_take) begin
            RVALID <= 1'b1;
        end else if (r_take) begin
            RVALID <= 1'b0;
        end
    end

    // data sampled once at the take, so it stands while RVALID waits
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 32'h00000000;
            RRESP <= `QDI_RESP_OKAY;
        end else if (ar_take) begin
            RDATA <= rd_d;
            RRESP <= rd_ok ? `QDI_RESP_OKAY : `QDI_RESP_SLVERR;
        end
    end
endmodule // qdi_top
`default_nettype wire

// ==== qdi_asserts.sv ====
// Purpose: bus handshake and irq checks
// Assumes: one clock, async low reset
// Notes: sees top ports only
`timescale 1ns/1ps
`default_nettype none
module qdi_asserts (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic SAMPLE_EVT,
    input wire logic OVFL_EVT,
    input wire logic STOPPED_EVT,
    input wire logic IRQ,
    input wire logic [1:0] BRESP,
    input wire logic [1:0] RRESP,
    input wire logic [11:0] ARADDR,
    input wire logic [31:0] RDATA
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    b_hold_a: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    r_hold_a: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    aw_block_a: assert property (
        BVALID |-> !AWREADY && !WREADY)
        else $error("write taken during response");
    ar_block_a: assert property (
        RVALID |-> !ARREADY)
        else $error("read taken during response");
    wr_resp_a: assert property (
        AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
        else $error("no write response");
    rd_unmap_a: assert property (
        ARVALID && ARREADY && ARADDR == 12'h200
        |=> RVALID && RRESP == 2'h2)
        else $error("bad unmapped read");
    irq_rise_a: assert property (
        $rose(IRQ) |-> $past(SAMPLE_EVT) || $past(SAMPLE_EVT, 2) ||
        $past(SAMPLE_EVT, 3) || $past(OVFL_EVT) ||
        $past(STOPPED_EVT) || $rose(BVALID))
        else $error("irq no cause");
    irq_fall_a: assert property (
        $fell(IRQ) |-> $rose(BVALID))
        else $error("irq fell without write");
endmodule // qdi_asserts
bind qdi_top qdi_asserts u_chk (.*);
`default_nettype wire

// ==== tb_qdi_top.sv ====
// Purpose: random and corner tests of the decoder irq block
// Assumes: report period setting 0 gives 10 samples
// Notes: wstrb all-on but for one lane-0-off write; lane 0 carries the mask
`timescale 1ns/1ps
`default_nettype none
module tb_qdi_top;
    logic SYS_CLK = 0, RST_B = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic ARVALID = 0, RREADY = 0, SAMPLE_EVT = 0, OVFL_EVT = 0;
    logic STOPPED_EVT = 0, k;
    logic [11:0] AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, rv, d;
    logic [3:0] WSTRB = 4'hF;
    logic [15:0] MOTION_SUM = 0, DBL_SUM = 0;
    logic [1:0] rp, bp;
    logic [4:0] en;
    wire AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
    wire [1:0] BRESP, RRESP;
    wire [31:0] RDATA;
    int n_fail = 0, tests_run = 0;
    qdi_top dut (.*);
    initial forever #2 SYS_CLK = ~SYS_CLK;
    task chk(input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %0t %h %h", $time, s, e);
        end
    endtask
    // expected mask after a write of v to the set or clear register
    function automatic logic [4:0] next_mask(input logic [4:0] m,
        input logic [31:0] v, input logic clr);
        next_mask = clr ? (m & ~v[4:0]) : (m | v[4:0]);
    endfunction
    task conclude;
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // readys sampled at negedge, stable until the next rising edge
    task wr(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge SYS_CLK);
        {AWADDR, WDATA} <= {a, v};
        {AWVALID, WVALID, BREADY} <= 3'h7;
        while (!(ta && tw)) begin
            @(negedge SYS_CLK);
            ta = ta | AWREADY;
            tw = tw | WREADY;
            @(posedge SYS_CLK);
            if (ta) AWVALID <= 0;
            if (tw) WVALID <= 0;
        end
        do @(negedge SYS_CLK); while (!BVALID);
        bp = BRESP;
        @(posedge SYS_CLK) BREADY <= 0;
    endtask
    task rd(input logic [11:0] a);
        @(posedge SYS_CLK);
        {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
        do @(negedge SYS_CLK); while (!ARREADY);
        @(posedge SYS_CLK) ARVALID <= 0;
        do @(negedge SYS_CLK); while (!RVALID);
        {rv, rp} = {RDATA, RRESP};
        @(posedge SYS_CLK) RREADY <= 0;
    endtask
    task pulse(input logic [2:0] e, input int n);
        repeat (n) begin
            @(posedge SYS_CLK) {STOPPED_EVT, OVFL_EVT, SAMPLE_EVT} <= e;
            @(posedge SYS_CLK) {STOPPED_EVT, OVFL_EVT, SAMPLE_EVT} <= 0;
        end
        repeat (3) @(posedge SYS_CLK);
    endtask
    initial begin
        void'($urandom(19404));
        repeat (8) @(posedge SYS_CLK);
        RST_B <= 1;
        rd(12'h304);
        chk(rv, 0);
        rd(12'h308);
        chk(rv, 0);
        rd(12'h200);
        chk(rp, 2'h2);
        chk(rv, 0);
        wr(12'h200, 32'h1F);
        chk(bp, 2'h2);
        rd(12'h304);
        chk(rv, 0);
        for (int i = 0; i < 5; i++) begin
            wr(12'h308, 32'h1F);
            wr(12'h304, 32'h1 << i);
            chk(bp, 2'h0);
            rd(12'h308);
            chk(rv, 32'h1 << i);
        end
        en = 5'h10;
        WSTRB <= 4'hE;
        wr(12'h304, 32'h1F);
        WSTRB <= 4'hF;
        rd(12'h304);
        chk(rv, {27'h0, en});
        repeat (40) begin
            d = $urandom;
            k = d[31];
            wr(k ? 12'h308 : 12'h304, d[30] ? d : 0);
            en = next_mask(en, d[30] ? d : 0, k);
            rd(d[29] ? 12'h308 : 12'h304);
            chk(rv, {27'h0, en});
        end
        wr(12'h308, 32'h1F);
        pulse(3'h4, 1);
        chk(IRQ, 0);
        wr(12'h304, 32'h10);
        chk(IRQ, 1);
        wr(12'h308, 32'h10);
        chk(IRQ, 0);
        wr(12'h304, 32'h0A);
        MOTION_SUM <= 16'h0005;
        pulse(3'h1, 10);
        rd(12'h100);
        chk(rv, 32'h13);
        chk(IRQ, 1);
        wr(12'h100, 32'h1F);
        {MOTION_SUM, DBL_SUM} <= {16'h0, 16'h0007};
        pulse(3'h1, 10);
        rd(12'h100);
        chk(rv, 32'h09);
        conclude;
    end
    initial begin
        #40000;
        n_fail++;
        conclude;
    end
endmodule // tb_qdi_top
`default_nettype wire
